// ==== logic/dcgt_cnt8.sv ====
/*
 One 8-bit up counter with software load and carry out.
 Assumes the tick is a one-cycle enable on the module clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dcgt_cnt8 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire logic [7:0] load_val,
    // State
    output logic [7:0] count,
    output logic wrap
);
    logic [7:0] next_count;

    assign wrap = tick && !load && (count == 8'hff);
    // Wraps from all ones to zero
    assign next_count = load ? load_val : (tick ? count + 8'h01 : count);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule

`default_nettype wire

// ==== logic/dcgt_params.svh ====
/*
 Register offsets, field positions, reset values and the decoder width for the
 dual 8-bit gated counter block. Assumes inclusion by the package, the top
 module, the checker and the bench; holds definitions alone.
*/
// Function
// - two independent eight-bit counters
// - six three-state digital outputs
// - dedicated input pin triggers one counter
// - per-counter clock select: external, auxiliary, main
// - counter A halts, runs, or gates
// - gate event sets shared interrupt flag
// - gate event stops gated counter
// - software reads and writes both counters
// - counters cascade into one sixteen-bit counter
// - all sources share one interrupt
// - separate mode: gate, overflow A, overflow B
// - cascade mode: gate or combined overflow
`ifndef DCGT_PARAMS_SVH
`define DCGT_PARAMS_SVH

`define DCGT_ADDR_W 3
`define DCGT_OFS_CTRL 3'h0
`define DCGT_OFS_CNTA 3'h1
`define DCGT_OFS_CNTB 3'h2
`define DCGT_OFS_STAT 3'h3
`define DCGT_OFS_MASK 3'h4
`define DCGT_OFS_OUTD 3'h5
`define DCGT_OFS_OUTE 3'h6

`define DCGT_CTRL_SRCA_LSB 0
`define DCGT_CTRL_SRCB_LSB 2
`define DCGT_CTRL_RUN_LSB 4
`define DCGT_CTRL_CASC_BIT 6
`define DCGT_CTRL_GPOL_BIT 7

`define DCGT_STAT_GATE_BIT 0
`define DCGT_STAT_OVFA_BIT 1
`define DCGT_STAT_OVFB_BIT 2

`define DCGT_CTRL_RST 8'h00
`define DCGT_MASK_RST 3'h0
`define DCGT_OUT_RST 6'h00

`endif

// ==== logic/dcgt_pkg.sv ====
/*
 Types for the dual 8-bit gated counter block.
 Assumes the params header is on the include path.
*/
`default_nettype none
`include "dcgt_params.svh"

package dcgt_pkg;

    // Clock source of one counter
    typedef enum logic [1:0] {
        DCGT_SRC_OFF,
        DCGT_SRC_EXT,
        DCGT_SRC_AUX,
        DCGT_SRC_MAIN
    } dcgt_src_t;

    // Run control of counter A
    typedef enum logic [1:0] {
        DCGT_RUN_HALT,
        DCGT_RUN_FREE,
        DCGT_RUN_GATE0,
        DCGT_RUN_GATE1
    } dcgt_run_t;

    typedef struct packed {
        logic gate_pol;
        logic cascade;
        dcgt_run_t run;
        dcgt_src_t src_b;
        dcgt_src_t src_a;
    } dcgt_ctrl_t;

    // Software register port
    typedef struct packed {
        logic [`DCGT_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dcgt_bus_t;

endpackage

`default_nettype wire

// ==== logic/dcgt_top.sv ====
/*
 Dual 8-bit counter with gating, cascade, sticky interrupt status and six
 three-state outputs. Assumes ref_clk at 20 MHz, sync active-high reset and a
 simple strobe register port; external pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcgt_params.svh"

module dcgt_top
    import dcgt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire dcgt_bus_t bus,
    output logic [7:0] rdata,
    // Clock sources
    input wire logic aux_clk_in,
    input wire logic main_clk_in,
    input wire logic ext_clk_a,
    input wire logic ext_clk_b,
    // Gate and trigger pins
    input wire logic trig_in,
    input wire logic gate_alt_in,
    // Three-state outputs
    output logic [5:0] tp_out,
    output logic [5:0] tp_oe,
    // Interrupt
    output logic irq
);
    localparam int NSRC = 6;

    dcgt_ctrl_t ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [NSRC-1:0] s1;
    logic [NSRC-1:0] s2;
    logic [NSRC-1:0] s3;
    logic gate_stop;

    // Pin order: aux, main, ext_a, ext_b, trig, gate_alt
    wire [NSRC-1:0] pins = {
        gate_alt_in,
        trig_in,
        ext_clk_b,
        ext_clk_a,
        main_clk_in,
        aux_clk_in
    };

    // Two-flop synchronisers, third flop for edge detect
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    s1[gi] <= 1'b0;
                    s2[gi] <= 1'b0;
                    s3[gi] <= 1'b0;
                end else begin
                    s1[gi] <= pins[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                end
            end
        end
    endgenerate

    wire [NSRC-1:0] rise = s2 & ~s3;
    wire aux_rise = rise[0];
    wire main_rise = rise[1];
    wire exta_rise = rise[2];
    wire extb_rise = rise[3];

    // Address decode
    wire sel_ctrl = bus.addr == `DCGT_OFS_CTRL;
    wire sel_cnta = bus.addr == `DCGT_OFS_CNTA;
    wire sel_cntb = bus.addr == `DCGT_OFS_CNTB;
    wire sel_stat = bus.addr == `DCGT_OFS_STAT;
    wire sel_mask = bus.addr == `DCGT_OFS_MASK;
    wire sel_outd = bus.addr == `DCGT_OFS_OUTD;
    wire sel_oute = bus.addr == `DCGT_OFS_OUTE;

    // Write strobes
    wire wr_ctrl = bus.wr && sel_ctrl;
    wire wr_cnta = bus.wr && sel_cnta;
    wire wr_cntb = bus.wr && sel_cntb;
    wire wr_stat = bus.wr && sel_stat;
    wire wr_mask = bus.wr && sel_mask;
    wire wr_outd = bus.wr && sel_outd;
    wire wr_oute = bus.wr && sel_oute;

    // Source tick per counter
    function automatic logic pick(input dcgt_src_t s, input logic ext);
        logic r;
        r = 1'b0;
        unique case (s)
            DCGT_SRC_OFF: r = 1'b0;
            DCGT_SRC_EXT: r = ext;
            DCGT_SRC_AUX: r = aux_rise;
            DCGT_SRC_MAIN: r = main_rise;
        endcase
        return r;
    endfunction

    wire src_tick_a = pick(ctrl.src_a, exta_rise);
    wire src_tick_b = pick(ctrl.src_b, extb_rise);

    // Gate selection: dedicated trigger pin or alternate pin
    wire gate_sel_gate0 = ctrl.run == DCGT_RUN_GATE0;
    wire gate_sel_gate1 = ctrl.run == DCGT_RUN_GATE1;
    wire gate_level = gate_sel_gate0 ? s2[4] : s2[5];
    wire gate_prev = gate_sel_gate0 ? s3[4] : s3[5];
    wire gate_act = gate_level ^ ctrl.gate_pol;
    wire gate_prev_act = gate_prev ^ ctrl.gate_pol;
    wire gated = gate_sel_gate0 || gate_sel_gate1;
    // Event is the end of the active gate window
    wire gate_event = gated && gate_prev_act && !gate_act;

    // Run enable for counter A
    logic run_a;
    always_comb begin
        run_a = 1'b0;
        unique case (ctrl.run)
            DCGT_RUN_HALT: run_a = 1'b0;
            DCGT_RUN_FREE: run_a = 1'b1;
            DCGT_RUN_GATE0,
            DCGT_RUN_GATE1: run_a = gate_act && !gate_stop;
        endcase
    end

    // Stop latch: set by the gate event, rearmed by writing A or control
    // Set wins so a gate event beside a rearm write is not lost
    wire gate_rearm = wr_cnta || wr_ctrl;
    logic next_gate_stop;
    assign next_gate_stop = gate_event || (gate_stop && !gate_rearm);

    // Counters
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic wrap_a;
    logic wrap_b;
    wire tick_a = src_tick_a && run_a;
    // In cascade B counts A overflows
    wire tick_b = ctrl.cascade ? wrap_a : src_tick_b;

    dcgt_cnt8 u_cnt_a (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick_a),
        .load(wr_cnta),
        .load_val(bus.wdata),
        .count(cnt_a),
        .wrap(wrap_a)
    );

    dcgt_cnt8 u_cnt_b (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick_b),
        .load(wr_cntb),
        .load_val(bus.wdata),
        .count(cnt_b),
        .wrap(wrap_b)
    );

    // Interrupt events by mode
    logic [2:0] ev;
    always_comb begin
        ev = 3'h0;
        ev[`DCGT_STAT_GATE_BIT] = gate_event;
        if (ctrl.cascade) begin
            ev[`DCGT_STAT_OVFB_BIT] = wrap_b;
        end else begin
            ev[`DCGT_STAT_OVFA_BIT] = wrap_a;
            ev[`DCGT_STAT_OVFB_BIT] = wrap_b;
        end
    end

    // Set wins over write-one-to-clear
    wire [2:0] clr = wr_stat ? bus.wdata[2:0] : 3'h0;
    wire [2:0] next_stat = (stat & ~clr) | ev;

    // Single shared request
    assign irq = |(stat & mask);

    // Three-state outputs
    logic [5:0] out_d;
    logic [5:0] out_e;
    assign tp_out = out_d;
    assign tp_oe = out_e;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= `DCGT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= bus.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask <= `DCGT_MASK_RST;
        end else if (wr_mask) begin
            mask <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_d <= `DCGT_OUT_RST;
        end else if (wr_outd) begin
            out_d <= bus.wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_e <= `DCGT_OUT_RST;
        end else if (wr_oute) begin
            out_e <= bus.wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gate_stop <= 1'b0;
        end else begin
            gate_stop <= next_gate_stop;
        end
    end

    // Sticky status, one flop per event
    generate
        for (gi = 0; gi < 3; gi++) begin : g_stat
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    stat[gi] <= 1'b0;
                end else begin
                    stat[gi] <= next_stat[gi];
                end
            end
        end
    endgenerate

    // Read mux, registered
    logic [7:0] rmux;
    always_comb begin
        rmux = 8'h00;
        unique case (bus.addr)
            `DCGT_OFS_CTRL: rmux = ctrl;
            `DCGT_OFS_CNTA: rmux = cnt_a;
            `DCGT_OFS_CNTB: rmux = cnt_b;
            `DCGT_OFS_STAT: rmux = {5'h00, stat};
            `DCGT_OFS_MASK: rmux = {5'h00, mask};
            `DCGT_OFS_OUTD: rmux = {2'h0, out_d};
            `DCGT_OFS_OUTE: rmux = {2'h0, out_e};
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= bus.rd ? rmux : 8'h00;
        end
    end
endmodule

`default_nettype wire

// ==== sim/dcgt_src_model.sv ====
/* Pin sources for dcgt_top: clock and gate pins. Assumes calls just after a ref_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module dcgt_src_model (
    // Clock
    input wire logic ref_clk,
    // Pins: ext a, ext b, aux, main, trig, alt gate
    output logic [5:0] pins
);
    initial pins = 6'h00;
    // Wide pulses to clear the two-flop sync
    task automatic pulse(input logic [5:0] sel, input int n);
        repeat (n) begin
            repeat (4) @(posedge ref_clk);
            pins <= pins | sel;
            repeat (4) @(posedge ref_clk);
            pins <= pins & ~sel;
        end
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic level(input int i, input logic v);
        pins[i] <= v;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== sim/dcgt_top_asserts.sv ====
/* Port checker for dcgt_top. Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
`include "dcgt_params.svh"
module dcgt_top_asserts
    import dcgt_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire dcgt_bus_t bus,
    input wire logic [7:0] rdata,
    // Pins
    input wire logic aux_clk_in,
    input wire logic main_clk_in,
    input wire logic ext_clk_a,
    input wire logic ext_clk_b,
    input wire logic trig_in,
    input wire logic gate_alt_in,
    input wire logic [5:0] tp_out,
    input wire logic [5:0] tp_oe,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic w_od = bus.wr && bus.addr == `DCGT_OFS_OUTD;
    wire logic w_oe = bus.wr && bus.addr == `DCGT_OFS_OUTE;
    wire logic w_mk = bus.wr && bus.addr == `DCGT_OFS_MASK;
    wire logic w_st = bus.wr && bus.addr == `DCGT_OFS_STAT;
    property p_idle; !bus.rd |=> rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata without read");
    property p_unmap; bus.rd && bus.addr == 3'h7 |=> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_oe; w_oe |=> tp_oe == $past(bus.wdata[5:0]); endproperty
    a_oe: assert property (p_oe) else $error("enable write");
    property p_od; w_od |=> tp_out == $past(bus.wdata[5:0]); endproperty
    a_od: assert property (p_od) else $error("data write");
    property p_hold; !w_od |=> $stable(tp_out); endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_rdoe; bus.rd && bus.addr == `DCGT_OFS_OUTE |=> rdata[5:0] == $past(tp_oe);
    endproperty
    a_rdoe: assert property (p_rdoe) else $error("enable readback");
    property p_mask; w_mk && bus.wdata[2:0] == 3'h0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_stick; irq && !w_mk && !w_st |=> irq; endproperty
    a_stick: assert property (p_stick) else $error("irq dropped");
endmodule
bind dcgt_top dcgt_top_asserts u_chk (.ref_clk, .sys_rst, .bus, .rdata, .aux_clk_in,
    .main_clk_in, .ext_clk_a, .ext_clk_b, .trig_in, .gate_alt_in, .tp_out, .tp_oe, .irq);
`default_nettype wire

// ==== sim/tb.sv ====
/* Self-checking bench for dcgt_top. Assumes the pin model and checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
`include "dcgt_params.svh"
module tb
    import dcgt_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    dcgt_bus_t bus = '0;
    logic [7:0] rdata;
    logic [5:0] pins, tp_out, tp_oe;
    logic irq;
    int bad_count = 0;
    int checked = 0;
    dcgt_top u_dut (.ref_clk, .sys_rst, .bus, .rdata, .aux_clk_in(pins[2]),
        .main_clk_in(pins[3]), .ext_clk_a(pins[0]), .ext_clk_b(pins[1]), .trig_in(pins[4]),
        .gate_alt_in(pins[5]), .tp_out, .tp_oe, .irq);
    dcgt_src_model u_src (.ref_clk, .pins);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        @(posedge ref_clk);
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        @(posedge ref_clk);
        chk(rdata, exp);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
        wr_reg(`DCGT_OFS_OUTD, 8'h2a);
        wr_reg(`DCGT_OFS_OUTE, 8'h15);
        chk({2'b00, tp_out}, 8'h2a);
        chk({2'b00, tp_oe}, 8'h15);
        rd_reg(`DCGT_OFS_OUTE, 8'h15);
        wr_reg(`DCGT_OFS_CNTA, 8'h5a);
        wr_reg(`DCGT_OFS_CNTB, 8'ha5);
        rd_reg(`DCGT_OFS_CNTA, 8'h5a);
        rd_reg(`DCGT_OFS_CNTB, 8'ha5);
        $display("registers done");
        for (int s = 1; s < 4; s++) begin
            wr_reg(`DCGT_OFS_CNTA, 8'h00);
            wr_reg(`DCGT_OFS_CNTB, 8'h00);
            wr_reg(`DCGT_OFS_CTRL, {2'b00, DCGT_RUN_FREE, s[1:0], s[1:0]});
            u_src.pulse(s == 1 ? 6'h03 : 6'h01 << s, 3);
            wr_reg(`DCGT_OFS_CTRL, 8'h00);
            rd_reg(`DCGT_OFS_CNTA, 8'h03);
            rd_reg(`DCGT_OFS_CNTB, 8'h03);
        end
        wr_reg(`DCGT_OFS_CNTB, 8'h00);
        wr_reg(`DCGT_OFS_CTRL, {2'b00, DCGT_RUN_HALT, DCGT_SRC_MAIN, DCGT_SRC_MAIN});
        u_src.pulse(6'h08, 2);
        rd_reg(`DCGT_OFS_CNTA, 8'h03);
        rd_reg(`DCGT_OFS_CNTB, 8'h02);
        $display("sources done");
        wr_reg(`DCGT_OFS_MASK, 8'h07);
        wr_reg(`DCGT_OFS_CNTA, 8'hff);
        wr_reg(`DCGT_OFS_CNTB, 8'hff);
        wr_reg(`DCGT_OFS_CTRL, {2'b00, DCGT_RUN_FREE, DCGT_SRC_MAIN, DCGT_SRC_MAIN});
        u_src.pulse(6'h08, 1);
        wr_reg(`DCGT_OFS_CTRL, 8'h00);
        rd_reg(`DCGT_OFS_STAT, 8'h06);
        rd_reg(`DCGT_OFS_CNTA, 8'h00);
        chk({7'h00, irq}, 8'h01);
        wr_reg(`DCGT_OFS_STAT, 8'h00);
        rd_reg(`DCGT_OFS_STAT, 8'h06);
        wr_reg(`DCGT_OFS_MASK, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr_reg(`DCGT_OFS_MASK, 8'h04);
        chk({7'h00, irq}, 8'h01);
        wr_reg(`DCGT_OFS_STAT, 8'h06);
        chk({7'h00, irq}, 8'h00);
        $display("overflow done");
        for (int k = 0; k < 2; k++) begin
            wr_reg(`DCGT_OFS_CNTA, 8'hff);
            wr_reg(`DCGT_OFS_CNTB, k ? 8'hff : 8'h12);
            wr_reg(`DCGT_OFS_CTRL, {2'b01, DCGT_RUN_FREE, DCGT_SRC_OFF, DCGT_SRC_MAIN});
            u_src.pulse(6'h08, 1);
            wr_reg(`DCGT_OFS_CTRL, 8'h00);
            rd_reg(`DCGT_OFS_CNTB, k ? 8'h00 : 8'h13);
            rd_reg(`DCGT_OFS_STAT, k ? 8'h04 : 8'h00);
            chk({7'h00, irq}, k ? 8'h01 : 8'h00);
        end
        wr_reg(`DCGT_OFS_STAT, 8'h07);
        $display("cascade done");
        for (int g = 0; g < 3; g++) begin
            wr_reg(`DCGT_OFS_CNTA, 8'h00);
            wr_reg(`DCGT_OFS_CTRL, g == 2 ? 8'ha3 : (g ? 8'h33 : 8'h23));
            u_src.level(4 + g[0], !g[1]);
            u_src.pulse(6'h08, 2);
            u_src.level(4 + g[0], g[1]);
            u_src.level(4 + g[0], !g[1]);
            u_src.pulse(6'h08, 2);
            u_src.level(4 + g[0], g[1]);
            rd_reg(`DCGT_OFS_CNTA, 8'h02);
            rd_reg(`DCGT_OFS_STAT, 8'h01);
            wr_reg(`DCGT_OFS_STAT, 8'h07);
        end
        $display("gate done");
        give_verdict();
    end
    initial begin
        repeat (8000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
